// File: rtl/stomon_params.svh
// Constants for the two-channel torque-off request monitor
`ifndef STOMON_PARAMS_SVH
`define STOMON_PARAMS_SVH
`define STOMON_CLK_HZ 20000000
`define STOMON_TICK_MS 10
`define STOMON_TICK_CYC ((`STOMON_CLK_HZ / 1000) * `STOMON_TICK_MS)
`define STOMON_DISC_MS 100
`define STOMON_DISC_TICKS (`STOMON_DISC_MS / `STOMON_TICK_MS)
`define STOMON_PULSE_US 1000
`define STOMON_PULSE_CYC ((`STOMON_CLK_HZ / 1000000) * `STOMON_PULSE_US)
`define STOMON_REPORT_TICKS 2
`define STOMON_SUPPLY_TICKS 2
`endif

// File: rtl/stomon_pkg.sv
// Types shared by the torque-off request monitor
package stomon_pkg;
  typedef enum logic [1:0] {
    STOMON_RUN,
    STOMON_DISC,
    STOMON_SAFE,
    STOMON_FAULT
  } stomon_state_t;

  typedef struct packed {
    logic safe_state;
    logic disc_error;
    logic mod_error;
    logic supply_error;
    logic mismatch;
  } stomon_status_t;
endpackage : stomon_pkg

// File: rtl/stomon_filter.sv
// Synchroniser and test-pulse filter for one request channel
`timescale 1ns/100ps
`include "stomon_params.svh"
module stomon_filter #(
  parameter int unsigned PULSE_CYC = `STOMON_PULSE_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic raw_i,
  output logic level_o
);
  logic sync_a;
  logic sync_b;
  logic [31:0] count;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
    end
  end

  // A low blip shorter than PULSE_CYC never reaches the output
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count <= 32'h0000_0000;
      level_o <= 1'b0;
    end else if (sync_b == level_o) begin
      count <= 32'h0000_0000;
    end else if (count >= PULSE_CYC - 1) begin
      count <= 32'h0000_0000;
      level_o <= sync_b;
    end else begin
      count <= count + 32'h0000_0001;
    end
  end
endmodule : stomon_filter

// File: rtl/stomon_top.sv
// Two-channel torque-off request monitor and supervisory state machine
// Operation
// - Enter torque off when both channels drop together or within the window.
// - Unequal channel levels are treated as a fault condition once the window runs out.
// - Second channel missing the window raises an error.
// - Default discrepancy window is 100 ms.
// - Supervisory machine updates once every 10 ms.
// - While torque off, driver supply stays switched off.
// - Supervisor checks driver supply voltage against the channel request.
// - Torque off is requested only through the two channels.
// - No cross-circuit detection on the request inputs.
// - Standstill position is not supervised in torque off.
// - Safe state is reported late, after hardware switch-off.
// - Request during active modulation gives an acknowledgeable error.
// - Short test pulses on the channels are not taken as requests.
`timescale 1ns/100ps
`include "stomon_params.svh"
module stomon_top #(
  parameter int unsigned TICK_CYC = `STOMON_TICK_CYC,
  parameter int unsigned PULSE_CYC = `STOMON_PULSE_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic torque_off_request_a_i,
  input wire logic torque_off_request_b_i,
  input wire logic driver_supply_ok_i,
  input wire logic modulation_active_i,
  input wire logic error_ack_i,
  output logic driver_supply_en_o,
  output logic status_tick_o,
  output stomon_pkg::stomon_status_t status_o
);
  import stomon_pkg::*;

  logic level_a;
  logic level_b;
  logic both_high;
  logic both_low;
  logic [31:0] tick_count;
  logic tick;
  stomon_state_t state;
  logic [7:0] disc_ticks;
  logic [7:0] safe_ticks;
  logic [7:0] supply_ticks;
  logic ack_sync_a;
  logic ack_sync_b;
  logic ack;
  logic disc_error;
  logic mod_error;
  logic supply_error;
  logic mod_active;
  logic mod_sync_a;
  logic supply_sync_a;
  logic supply_ok;

  //////////////////////////////////////////////////////////////////////////////
  // Channel inputs: high means run enabled, low means torque off requested.
  // No cross-wiring test is made here; that belongs to the outside relay.
  stomon_filter #(
    .PULSE_CYC(PULSE_CYC)
  ) u_filt_a (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .raw_i(torque_off_request_a_i),
    .level_o(level_a)
  );

  stomon_filter #(
    .PULSE_CYC(PULSE_CYC)
  ) u_filt_b (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .raw_i(torque_off_request_b_i),
    .level_o(level_b)
  );

  // Only these two levels can request torque off
  assign both_high = level_a & level_b;
  assign both_low = ~level_a & ~level_b;

  // Hardware path: supply off as soon as either channel drops, no tick wait
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      driver_supply_en_o <= 1'b0;
    end else begin
      driver_supply_en_o <= both_high;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Other asynchronous inputs
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ack_sync_a <= 1'b0;
      ack_sync_b <= 1'b0;
      ack <= 1'b0;
      mod_sync_a <= 1'b0;
      mod_active <= 1'b0;
      supply_sync_a <= 1'b0;
      supply_ok <= 1'b0;
    end else begin
      ack_sync_a <= error_ack_i;
      ack_sync_b <= ack_sync_a;
      ack <= ack_sync_b;
      mod_sync_a <= modulation_active_i;
      mod_active <= mod_sync_a;
      // Supply sense comes from the gate-driver side, not from this clock
      supply_sync_a <= driver_supply_ok_i;
      supply_ok <= supply_sync_a;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 10 ms supervisory tick
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tick_count <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (tick_count >= TICK_CYC - 1) begin
      tick_count <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  assign status_tick_o = tick;

  //////////////////////////////////////////////////////////////////////////////
  // Supervisory state machine, advances only on the tick.
  // Standstill position is deliberately not watched in the safe state.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= STOMON_RUN;
      disc_ticks <= 8'h00;
    end else if (tick) begin
      unique case (state)
        STOMON_RUN: begin
          if (both_low) begin
            state <= STOMON_SAFE;
          end else if (!both_high) begin
            state <= STOMON_DISC;
            disc_ticks <= 8'h01;
          end
        end
        STOMON_DISC: begin
          if (both_low) begin
            state <= STOMON_SAFE;
          end else if (both_high) begin
            state <= STOMON_RUN;
          end else if (disc_ticks >= 8'(`STOMON_DISC_TICKS)) begin
            state <= STOMON_FAULT;
          end else begin
            disc_ticks <= disc_ticks + 8'h01;
          end
        end
        STOMON_SAFE: begin
          if (both_high) begin
            state <= STOMON_RUN;
          end else if (!both_low) begin
            state <= STOMON_DISC;
            disc_ticks <= 8'h01;
          end
        end
        STOMON_FAULT: begin
          // Leave only once the channels agree again
          if (both_low) begin
            state <= STOMON_SAFE;
          end else if (both_high) begin
            state <= STOMON_RUN;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Latched errors; a new event in the acknowledge cycle wins over the clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      disc_error <= 1'b0;
    end else if (tick && state == STOMON_DISC && !both_low && !both_high
                 && disc_ticks >= 8'(`STOMON_DISC_TICKS)) begin
      disc_error <= 1'b1;
    end else if (ack) begin
      disc_error <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mod_error <= 1'b0;
    end else if (tick && state == STOMON_RUN && !both_high && mod_active) begin
      mod_error <= 1'b1;
    end else if (ack) begin
      mod_error <= 1'b0;
    end
  end

  // Supply monitor: supply must follow the request within a few ticks
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      supply_ticks <= 8'h00;
      supply_error <= 1'b0;
    end else begin
      if (tick) begin
        if (supply_ok == driver_supply_en_o) begin
          supply_ticks <= 8'h00;
        end else if (supply_ticks < 8'hFF) begin
          supply_ticks <= supply_ticks + 8'h01;
        end
      end
      // Set only while the mismatch persists, never on the tick that it clears
      if (tick && supply_ok != driver_supply_en_o
          && supply_ticks >= 8'(`STOMON_SUPPLY_TICKS)) begin
        supply_error <= 1'b1;
      end else if (ack) begin
        supply_error <= 1'b0;
      end
    end
  end

  // Safe state is only reported after a dwell, well after the switch-off
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      safe_ticks <= 8'h00;
    end else if (state != STOMON_SAFE) begin
      safe_ticks <= 8'h00;
    end else if (tick && safe_ticks < 8'(`STOMON_REPORT_TICKS)) begin
      safe_ticks <= safe_ticks + 8'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      status_o <= '0;
    end else begin
      status_o.safe_state <= (state == STOMON_SAFE)
                             && (safe_ticks >= 8'(`STOMON_REPORT_TICKS));
      status_o.disc_error <= disc_error;
      status_o.mod_error <= mod_error;
      status_o.supply_error <= supply_error;
      status_o.mismatch <= (state == STOMON_DISC) || (state == STOMON_FAULT);
    end
  end
endmodule : stomon_top

// File: verif/stomon_properties.sv
// Port-level checks for the torque-off request monitor
`timescale 1ns/100ps
module stomon_properties
  import stomon_pkg::*;
#(
  parameter int unsigned TICK_CYC = 20,
  parameter int unsigned PULSE_CYC = 4
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic torque_off_request_a_i,
  input wire logic torque_off_request_b_i,
  input wire logic driver_supply_ok_i,
  input wire logic modulation_active_i,
  input wire logic error_ack_i,
  input wire logic driver_supply_en_o,
  input wire logic status_tick_o,
  input wire stomon_pkg::stomon_status_t status_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire ra = torque_off_request_a_i;
  wire rb = torque_off_request_b_i;
  // Eight cycles covers the filter, two sync flops and the output register
  chk_both_low_off: assert property ((!ra && !rb)[*8] |=> !driver_supply_en_o)
    else $error("supply stays on after both channels dropped");
  chk_both_high_on: assert property ((ra && rb)[*8] |=> driver_supply_en_o)
    else $error("supply off with both channels high");
  chk_pulse_ignored: assert property ((ra && rb)[*5] ##0 driver_supply_en_o ##1 (!ra && rb)
    ##1 (ra && rb)[*6] |-> driver_supply_en_o) else $error("test pulse cut the supply");
  chk_tick_spacing: assert property (status_tick_o |=> !status_tick_o[*8])
    else $error("status ticks too close");
  chk_late_safe: assert property ($rose(status_o.safe_state) |-> !$past(driver_supply_en_o, 30))
    else $error("safe state reported before switch-off settled");
  chk_disc_late: assert property ($rose(status_o.disc_error) |-> $past(status_o.mismatch, 150))
    else $error("discrepancy error before the window ran out");
  chk_mismatch_tick: assert property ($rose(status_o.mismatch)
    |-> ($past(status_tick_o) || $past(status_tick_o, 2))) else $error("mismatch off tick");
  chk_error_held: assert property ((!error_ack_i)[*6] ##0 status_o.disc_error
    |=> status_o.disc_error) else $error("discrepancy error dropped without ack");
  cover property ($rose(status_o.safe_state));
  cover property ($rose(status_o.disc_error));
  cover property ($rose(status_o.mod_error));
  cover property ($rose(status_o.supply_error));
endmodule : stomon_properties
bind stomon_top stomon_properties #(.TICK_CYC(TICK_CYC), .PULSE_CYC(PULSE_CYC)) chk_inst (.*);

// File: verif/stomon_relay.sv
// Behavioural safety relay driving both request channels
`timescale 1ns/100ps
module stomon_relay (
  input wire logic clock_i,
  input wire logic level_i,
  input wire logic [7:0] skew_i,
  input wire logic pulse_i,
  output logic chan_a_o,
  output logic chan_b_o
);
  logic [7:0] lag = 8'h00;
  initial chan_a_o = 1'b1;
  initial chan_b_o = 1'b1;
  // Opening drops to 0 V; level only returns on command, so no automatic restart
  always @(posedge clock_i) chan_a_o <= level_i & ~pulse_i;
  // Second contact lags skew_i cycles; 8'hff models a welded contact
  always @(posedge clock_i) begin
    if (chan_b_o == level_i) begin
      lag <= 8'h00;
    end else if (lag >= skew_i && skew_i != 8'hff) begin
      chan_b_o <= level_i;
    end else begin
      lag <= lag + 8'h01;
    end
  end
endmodule : stomon_relay

// File: verif/stomon_top_bench.sv
// Self-checking bench for the torque-off request monitor
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %0t unexpected value", $time); end end
module stomon_top_bench;
  import stomon_pkg::*;
  localparam int unsigned TICK = 20;
  logic clock_i = 0, rst_i = 1, mod_act = 0, ack = 0, supply_ok = 0, fault = 0;
  logic level = 1, pulse = 0, req_a, req_b, supply_en, tick;
  logic [7:0] skew = 8'h00;
  stomon_status_t status;
  int error_cnt = 0, tests_run = 0;
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) supply_ok <= supply_en ^ fault;
  stomon_relay stomon_relay_inst (.clock_i(clock_i), .level_i(level), .skew_i(skew),
    .pulse_i(pulse), .chan_a_o(req_a), .chan_b_o(req_b));
  stomon_top #(.TICK_CYC(TICK), .PULSE_CYC(4)) stomon_top_inst (.clock_i(clock_i),
    .rst_i(rst_i), .torque_off_request_a_i(req_a), .torque_off_request_b_i(req_b),
    .driver_supply_ok_i(supply_ok), .modulation_active_i(mod_act), .error_ack_i(ack),
    .driver_supply_en_o(supply_en), .status_tick_o(tick), .status_o(status));
  task automatic finish_test;
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic wait_ticks(input int n);
    int seen = 0;
    for (int i = 0; i < n * TICK + 40 && seen < n; i++) begin
      @(posedge clock_i);
      if (tick === 1'b1) seen++;
    end
    if (seen < n) begin
      error_cnt++;
      $display("[FAIL] %0t no status tick", $time);
      finish_test();
    end
  endtask : wait_ticks
  // Ack is filtered by three flops, so hold it well beyond that
  task automatic do_ack;
    ack <= 1;
    repeat (8) @(posedge clock_i);
    ack <= 0;
    repeat (4) @(posedge clock_i);
  endtask : do_ack
  task automatic t_pulse;
    pulse <= 1;
    @(posedge clock_i);
    pulse <= 0;
    wait_ticks(2);
    `CHK(supply_en, 1'b1)
    `CHK(status, 5'h00)
  endtask : t_pulse
  task automatic t_supply;
    fault <= 1;
    wait_ticks(5);
    `CHK(status.supply_error, 1'b1)
    fault <= 0;
    do_ack();
    `CHK(status.supply_error, 1'b0)
    wait_ticks(2);
    `CHK(status.supply_error, 1'b0)
  endtask : t_supply
  task automatic t_mod_stop;
    mod_act <= 1;
    level <= 0;
    wait_ticks(5);
    `CHK(supply_en, 1'b0)
    `CHK(status.mod_error, 1'b1)
    `CHK(status.safe_state, 1'b1)
    mod_act <= 0;
    do_ack();
    `CHK(status.mod_error, 1'b0)
    level <= 1;
    wait_ticks(4);
    `CHK(supply_en, 1'b1)
  endtask : t_mod_stop
  task automatic t_skew_ok;
    skew <= 8'h64;
    level <= 0;
    wait_ticks(3);
    `CHK(status.mismatch, 1'b1)
    wait_ticks(7);
    `CHK(status.disc_error, 1'b0)
    `CHK(status.safe_state, 1'b1)
    skew <= 8'h00;
    level <= 1;
    wait_ticks(4);
  endtask : t_skew_ok
  task automatic t_disc;
    skew <= 8'hff;
    level <= 0;
    wait_ticks(13);
    `CHK(status.disc_error, 1'b1)
    `CHK(supply_en, 1'b0)
    skew <= 8'h00;
    wait_ticks(2);
    `CHK(status.disc_error, 1'b1)
    do_ack();
    `CHK(status.disc_error, 1'b0)
  endtask : t_disc
  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 0;
    wait_ticks(2);
    `CHK(supply_en, 1'b1)
    t_pulse();
    t_supply();
    t_mod_stop();
    t_skew_ok();
    t_disc();
    finish_test();
  end
endmodule : stomon_top_bench
